// ==== sqwt_device.sv ====
// Square-wave down timer device end
//
// Behaviour
// - Two mode bits choose output waveform
// - Square mode period equals count length
// - Low mode bit set means auto reload
// - Odd count: high half one longer
// - Mode in top bits, count below
// - Command bits 7:6 start or stop
// - Command 00 leaves counter alone
// - Command 01 halts running timer now
// - Command 10 stops after terminal count
// - Command 11 when idle loads, starts
// - Command 11 when running switches at TC
// - Rewritten count ignored until start command
// - Reset stops counter until start
// - Count decrements by two, once per timer_in cycle
// - Host never programs count of one; sqwt_host passes any count through unchecked
// - Host stops, reads count, clears mode
// - Host leaves right shift and carry fix to software
// - Correct pulses per output waveform
// - Host loads 2 to 3FFF bytewise; sqwt_host does not check the range
// - Low byte at 100, high at 101
// - Status bit 6 set at TC, read clears
`include "sqwt_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sqwt_device (
    input wire logic sys_clk,
    input wire logic rst_n,
    sqwt_if.device link,
    output logic timer_out,
    output logic running
);
    import sqwt_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [15:0] cnt_len;
        logic [13:0] count;
        sqwt_wave_type mode;
        logic [13:0] load_len;
        logic run;
        logic pending;
        logic stop_at_tc;
        logic second_half;
        logic tc_flag;
        logic pulse_end;
        logic out;
        logic in_s1;
        logic in_s2;
        logic in_s3;
        logic [7:0] rdata;
    } sqwt_dev_state_type;

    sqwt_dev_state_type st_r;
    sqwt_dev_state_type st_nxt;

    function automatic logic [13:0] sqwt_first_half(input logic [13:0] len);
        sqwt_first_half = {len[13:1], 1'b0} + {12'h000, len[0], 1'b0};
    endfunction : sqwt_first_half

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic edge_fall;
        logic at_tc;
        logic [1:0] cmd;
        logic [13:0] new_len;
        edge_fall = 1'b0;
        at_tc = 1'b0;
        cmd = 2'h0;
        new_len = 14'h0000;
        st_nxt = st_r;
        st_nxt.in_s1 = link.timer_in;
        st_nxt.in_s2 = st_r.in_s1;
        st_nxt.in_s3 = st_r.in_s2;
        edge_fall = st_r.in_s3 & ~st_r.in_s2;
        st_nxt.rdata = 8'h00;
        if (st_r.run && edge_fall) begin
            if (st_r.count <= `SQWT_TC_VALUE) begin
                at_tc = ~st_r.second_half | 1'b1;
                if (!st_r.second_half) begin
                    // End of first half: reload for second half
                    st_nxt.second_half = 1'b1;
                    st_nxt.count = {st_r.load_len[13:1], 1'b0};
                    at_tc = 1'b0;
                    if (st_r.mode == SQWT_WAVE_HALF_LOW ||
                        st_r.mode == SQWT_WAVE_SQUARE) begin
                        st_nxt.out = 1'b0;
                    end
                end
            end else begin
                st_nxt.count = st_r.count - 14'h0002;
                if (st_r.mode[1]) begin
                    st_nxt.out = 1'b1;
                end
            end
        end
        if (at_tc) begin
            // Terminal count of a whole output cycle
            st_nxt.tc_flag = 1'b1;
            st_nxt.second_half = 1'b0;
            new_len = st_r.pending ? st_r.cnt_len[13:0] : st_r.load_len;
            if (st_r.pending) begin
                st_nxt.mode = sqwt_wave_type'(st_r.cnt_len[15:14]);
                st_nxt.load_len = new_len;
                st_nxt.pending = 1'b0;
            end
            st_nxt.count = sqwt_first_half(new_len);
            st_nxt.out = st_r.mode[1] ? 1'b0 : 1'b1;
            if (st_r.stop_at_tc) begin
                st_nxt.run = 1'b0;
                st_nxt.stop_at_tc = 1'b0;
            end else if (!st_r.pending && !st_r.mode[0]) begin
                // Single pulse keeps running until its low period ends
                st_nxt.run = st_r.mode[1];
                st_nxt.pulse_end = st_r.mode[1];
            end
            if (st_r.pending) begin
                st_nxt.run = ~st_r.stop_at_tc;
            end
        end
        if (st_r.pulse_end && edge_fall) begin
            // End of single pulse: output back high, timer stops
            st_nxt.out = 1'b1;
            st_nxt.run = 1'b0;
            st_nxt.pulse_end = 1'b0;
            st_nxt.count = st_r.count;
        end
        if (link.wr) begin
            case (link.addr)
                `SQWT_ADDR_CNT_LO: begin
                    st_nxt.cnt_len[7:0] = link.wdata;
                end
                `SQWT_ADDR_CNT_HI: begin
                    st_nxt.cnt_len[15:8] = link.wdata;
                end
                `SQWT_ADDR_CMD: begin
                    cmd = link.wdata[`SQWT_CMD_POS +: 2];
                    case (sqwt_cmd_type'(cmd))
                        SQWT_CMD_NOP: begin
                            st_nxt.run = st_nxt.run;
                        end
                        SQWT_CMD_STOP: begin
                            st_nxt.run = 1'b0;
                            st_nxt.pending = 1'b0;
                            st_nxt.pulse_end = 1'b0;
                            st_nxt.stop_at_tc = 1'b0;
                        end
                        SQWT_CMD_STOP_AFTER_TC: begin
                            st_nxt.stop_at_tc = st_nxt.run;
                        end
                        SQWT_CMD_START: begin
                            if (!st_nxt.run) begin
                                st_nxt.mode = sqwt_wave_type'(st_nxt.cnt_len[15:14]);
                                st_nxt.load_len = st_nxt.cnt_len[13:0];
                                st_nxt.count = sqwt_first_half(st_nxt.cnt_len[13:0]);
                                st_nxt.second_half = 1'b0;
                                st_nxt.out = 1'b1;
                                st_nxt.pulse_end = 1'b0;
                                st_nxt.run = 1'b1;
                            end else begin
                                st_nxt.pending = 1'b1;
                                st_nxt.stop_at_tc = 1'b0;
                            end
                        end
                        default: begin
                            st_nxt.run = st_nxt.run;
                        end
                    endcase
                end
                default: begin
                    st_nxt.cnt_len = st_nxt.cnt_len;
                end
            endcase
        end
        if (link.rd) begin
            case (link.addr)
                `SQWT_ADDR_CMD: begin
                    st_nxt.rdata = {1'b0, st_r.tc_flag, 6'h00};
                    st_nxt.tc_flag = at_tc;
                end
                `SQWT_ADDR_CNT_LO: begin
                    // Counter value kept after stop for remaining count
                    st_nxt.rdata = st_r.count[7:0];
                end
                `SQWT_ADDR_CNT_HI: begin
                    st_nxt.rdata = {st_r.mode, st_r.count[13:8]};
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.out <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.rdata = st_r.rdata;
    assign timer_out = st_r.out;
    assign running = st_r.run;
endmodule : sqwt_device
`default_nettype wire

// ==== sqwt_defs.svh ====
// Constants of the square-wave down timer
`ifndef SQWT_DEFS_SVH
`define SQWT_DEFS_SVH
`define SQWT_ADDR_CMD 3'h0
`define SQWT_ADDR_CNT_LO 3'h4
`define SQWT_ADDR_CNT_HI 3'h5
`define SQWT_CMD_POS 6
`define SQWT_MODE_POS 14
`define SQWT_STAT_TIMER_POS 6
`define SQWT_TC_VALUE 14'h0002
`define SQWT_CNT_RESET 16'h0000
`define SQWT_CTL_ADDR_STATUS 2'h0
`define SQWT_CTL_ADDR_CNTLEN 2'h1
`define SQWT_CTL_ADDR_CMD 2'h2
`define SQWT_CTL_ADDR_RDBACK 2'h3
`endif

// ==== sqwt_pkg.sv ====
// Types of the square-wave down timer
package sqwt_pkg;
    typedef enum logic [1:0] {
        SQWT_WAVE_HALF_LOW,
        SQWT_WAVE_SQUARE,
        SQWT_WAVE_PULSE_ONCE,
        SQWT_WAVE_PULSE_REPEAT
    } sqwt_wave_type;
    typedef enum logic [1:0] {
        SQWT_CMD_NOP,
        SQWT_CMD_STOP,
        SQWT_CMD_STOP_AFTER_TC,
        SQWT_CMD_START
    } sqwt_cmd_type;
    typedef enum logic [1:0] {
        SQWT_BUS_IDLE,
        SQWT_BUS_WRITE,
        SQWT_BUS_READ
    } sqwt_bus_type;
endpackage : sqwt_pkg

// ==== sqwt_if.sv ====
// Register link between host controller and timer device
`timescale 1ns/10ps
`default_nettype none
interface sqwt_if;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic timer_in;
    modport device (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        input timer_in
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        output timer_in
    );
endinterface : sqwt_if
`default_nettype wire

// ==== sqwt_host.sv ====
// Host controller end driving the timer registers
`include "sqwt_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sqwt_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    sqwt_if.host link,
    input wire logic [1:0] ctl_addr,
    input wire logic [15:0] ctl_wdata,
    input wire logic ctl_wr,
    input wire logic ctl_rd,
    output logic [15:0] ctl_rdata,
    input wire logic pulse_in
);
    import sqwt_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        sqwt_bus_type bus;
        logic [1:0] step;
        logic [15:0] hold;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic [7:0] status;
        logic [15:0] rdback;
        logic [15:0] rdata;
        logic busy;
        logic tin;
        logic stat_due;
    } sqwt_host_state_type;

    sqwt_host_state_type st_r;
    sqwt_host_state_type st_nxt;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        st_nxt.rd = 1'b0;
        st_nxt.rdata = 16'h0000;
        st_nxt.tin = pulse_in;
        if (ctl_rd) begin
            case (ctl_addr)
                `SQWT_CTL_ADDR_STATUS: st_nxt.rdata = {7'h00, st_r.busy, st_r.status};
                `SQWT_CTL_ADDR_RDBACK: st_nxt.rdata = st_r.rdback;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        case (st_r.bus)
            SQWT_BUS_IDLE: begin
                if (ctl_wr && ctl_addr == `SQWT_CTL_ADDR_CNTLEN) begin
                    // Bytewise load, low byte first
                    st_nxt.hold = ctl_wdata;
                    st_nxt.bus = SQWT_BUS_WRITE;
                    st_nxt.step = 2'h0;
                    st_nxt.busy = 1'b1;
                end else if (ctl_wr && ctl_addr == `SQWT_CTL_ADDR_CMD) begin
                    st_nxt.addr = `SQWT_ADDR_CMD;
                    st_nxt.wdata = ctl_wdata[7:0];
                    st_nxt.wr = 1'b1;
                end else if (ctl_wr && ctl_addr == `SQWT_CTL_ADDR_RDBACK) begin
                    // Stop, then read count and status
                    st_nxt.addr = `SQWT_ADDR_CMD;
                    st_nxt.wdata = {SQWT_CMD_STOP, 6'h00};
                    st_nxt.wr = 1'b1;
                    st_nxt.bus = SQWT_BUS_READ;
                    st_nxt.step = 2'h0;
                    st_nxt.busy = 1'b1;
                end
            end
            SQWT_BUS_WRITE: begin
                st_nxt.wr = 1'b1;
                st_nxt.step = st_r.step + 2'h1;
                if (st_r.step == 2'h0) begin
                    st_nxt.addr = `SQWT_ADDR_CNT_LO;
                    st_nxt.wdata = st_r.hold[7:0];
                end else begin
                    st_nxt.addr = `SQWT_ADDR_CNT_HI;
                    st_nxt.wdata = st_r.hold[15:8];
                    st_nxt.bus = SQWT_BUS_IDLE;
                    st_nxt.busy = 1'b0;
                end
            end
            SQWT_BUS_READ: begin
                st_nxt.step = st_r.step + 2'h1;
                case (st_r.step)
                    2'h0: begin
                        st_nxt.addr = `SQWT_ADDR_CNT_LO;
                        st_nxt.rd = 1'b1;
                    end
                    2'h1: begin
                        st_nxt.addr = `SQWT_ADDR_CNT_HI;
                        st_nxt.rd = 1'b1;
                    end
                    2'h2: begin
                        st_nxt.rdback[7:0] = link.rdata;
                        st_nxt.addr = `SQWT_ADDR_CMD;
                        st_nxt.rd = 1'b1;
                    end
                    default: begin
                        // Mode bits cleared, left for software shift
                        st_nxt.rdback[15:8] = {2'b00, link.rdata[5:0]};
                        st_nxt.bus = SQWT_BUS_IDLE;
                        st_nxt.busy = 1'b0;
                    end
                endcase
            end
            default: st_nxt.bus = SQWT_BUS_IDLE;
        endcase
        // Status answer stands one cycle after the read strobe
        st_nxt.stat_due = st_r.rd && st_r.addr == `SQWT_ADDR_CMD;
        if (st_r.stat_due) begin
            st_nxt.status = link.rdata;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.addr = st_r.addr;
    assign link.wdata = st_r.wdata;
    assign link.wr = st_r.wr;
    assign link.rd = st_r.rd;
    assign link.timer_in = st_r.tin;
    assign ctl_rdata = st_r.rdata;
endmodule : sqwt_host
`default_nettype wire

// ==== sqwt_assertions.sv ====
// Checker on the link between host controller and timer device
`timescale 1ns/10ps
`default_nettype none
module sqwt_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic timer_in,
    input wire logic timer_out,
    input wire logic running
);
    // ****************************************
    // Link and timer properties
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic cmd_wr;
    assign cmd_wr = wr && (addr == 3'h0);
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    chk_start_runs: assert property (cmd_wr && wdata[7:6] == 2'h3 |=> running)
        else $error("start command did not start timer");
    chk_stop_halts: assert property (cmd_wr && wdata[7:6] == 2'h1 |=> !running [*2])
        else $error("stop command did not halt timer");
    chk_nop_keeps: assert property (cmd_wr && wdata[7:6] == 2'h0 && timer_in
        && $past(timer_in) && $past(timer_in, 2) && $past(timer_in, 3)
        |=> running == $past(running))
        else $error("empty command changed timer state");
    chk_late_stop_waits: assert property (cmd_wr && wdata[7:6] == 2'h2 && running
        && timer_in && $past(timer_in) && $past(timer_in, 2) && $past(timer_in, 3)
        |=> running)
        else $error("stop after terminal count halted at once");
    chk_reset_stops: assert property ($rose(rst_n) |-> !running && timer_out)
        else $error("timer not stopped after reset");
    chk_out_has_cause: assert property ($changed(timer_out)
        |-> $past(running) || $past(cmd_wr))
        else $error("timer output moved while idle");
    chk_wr_rd_excl: assert property (!(wr && rd))
        else $error("write and read strobes together");
    chk_addr_map: assert property ((wr || rd) |-> addr inside {3'h0, 3'h4, 3'h5})
        else $error("access outside timer register map");
endmodule : sqwt_assertions
`default_nettype wire

// ==== test_square_wave_down_timer.sv ====
// Testbench of the square-wave down timer, both ends joined
`timescale 1ns/10ps
`default_nettype none
`define SQWT_CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module test_square_wave_down_timer;
    import sqwt_pkg::*;
    // ****************************************
    // Design, link and checker
    // ****************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] ctl_addr = 2'h0;
    logic [15:0] ctl_wdata = 16'h0000;
    logic ctl_wr = 1'b0;
    logic ctl_rd = 1'b0;
    logic [15:0] ctl_rdata;
    logic pulse_in = 1'b1;
    logic timer_out;
    logic running;
    int error_cnt = 0;
    int total_checks = 0;
    sqwt_if link ();
    sqwt_device i_sqwt_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .timer_out(timer_out), .running(running));
    sqwt_host i_sqwt_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
        .ctl_rdata(ctl_rdata), .pulse_in(pulse_in));
    sqwt_assertions i_sqwt_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
        .rdata(link.rdata), .timer_in(link.timer_in), .timer_out(timer_out),
        .running(running));
    always #10 sys_clk = ~sys_clk;
    // ****************************************
    // Bus and pulse tasks
    // ****************************************
    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic ctl_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        ctl_addr <= a;
        ctl_wdata <= d;
        ctl_wr <= 1'b1;
        @(posedge sys_clk);
        ctl_wr <= 1'b0;
        repeat (7) @(posedge sys_clk);
        #1;
    endtask : ctl_write
    task automatic ctl_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        ctl_addr <= a;
        ctl_rd <= 1'b1;
        @(posedge sys_clk);
        ctl_rd <= 1'b0;
        #1;
        d = ctl_rdata;
    endtask : ctl_read
    task automatic load(input logic [1:0] m, input int n);
        ctl_write(2'h1, {m, n[13:0]});
    endtask : load
    task automatic cmd(input logic [1:0] c);
        ctl_write(2'h2, {8'h00, c, 6'h00});
    endtask : cmd
    task automatic step(input logic e);
        @(posedge sys_clk);
        pulse_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pulse_in <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        `SQWT_CHK("timer_out", e, timer_out)
    endtask : step
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic run_mode(input logic [1:0] m, input int n);
        logic [15:0] d;
        logic e;
        load(m, n);
        cmd(2'h3);
        `SQWT_CHK("running", 1'b1, running)
        for (int k = 1; k <= 2 * n; k++) begin
            case (m)
                2'h0: e = (k < (n + 1) / 2) || (k >= n);
                2'h1: e = (k % n) < (n + 1) / 2;
                2'h2: e = (k != n);
                default: e = (k % n) != 0;
            endcase
            step(e);
            if (k == n + 1) begin
                `SQWT_CHK("running", m[0], running)
            end
        end
        ctl_write(2'h3, 16'h0000);
        ctl_read(2'h0, d);
        `SQWT_CHK("status", 1'b1, d[6])
        ctl_write(2'h3, 16'h0000);
        ctl_read(2'h0, d);
        `SQWT_CHK("status", 1'b0, d[6])
        `SQWT_CHK("running", 1'b0, running)
    endtask : run_mode
    task automatic late_switch;
        load(2'h1, 4);
        cmd(2'h3);
        step(1'b1);
        load(2'h3, 6);
        cmd(2'h0);
        `SQWT_CHK("running", 1'b1, running)
        for (int k = 2; k <= 5; k++) begin
            step((k % 4) < 2);
        end
        cmd(2'h3);
        for (int k = 6; k <= 8; k++) begin
            step((k % 4) < 2);
        end
        for (int j = 1; j <= 6; j++) begin
            step((j % 6) != 0);
        end
        cmd(2'h2);
        for (int j = 1; j <= 5; j++) begin
            step((j % 6) != 0);
        end
        `SQWT_CHK("running", 1'b1, running)
        step(1'b0);
        `SQWT_CHK("running", 1'b0, running)
    endtask : late_switch
    task automatic readback;
        logic [15:0] d;
        load(2'h1, 8);
        cmd(2'h3);
        step(1'b1);
        ctl_write(2'h3, 16'h0000);
        `SQWT_CHK("running", 1'b0, running)
        ctl_read(2'h3, d);
        `SQWT_CHK("readback", 1'b1, d[15:14] == 2'h0 && d[13:0] < 14'h0008 && !d[0])
    endtask : readback
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        `SQWT_CHK("running", 1'b0, running)
        `SQWT_CHK("timer_out", 1'b1, timer_out)
        cmd(2'h1);
        `SQWT_CHK("running", 1'b0, running)
        for (int m = 0; m < 4; m++) begin
            run_mode(m[1:0], 5);
        end
        late_switch();
        readback();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        final_report();
    end
endmodule : test_square_wave_down_timer
`default_nettype wire
